// File: hw/tpc_params.svh
// timescale and timing-pulse control: offsets, reset values, timing counts
// assumes a 100 MHz clock and word-addressed Avalon-MM register access
//
// Functional notes
// RL1 - mains and battery fault masks act independently
// RL2 - loop hold suppresses automatic oscillator corrections
// RL3 - auxiliary alarm normal or special, special unimplemented
// RL4 - local equals UTC plus signed zone offset
// RL5 - updating on with fix refuses entry, beeps
// RL6 - updating on without fix: entry realigns outputs
// RL7 - later fix overwrites entry, retimes to UTC
// RL8 - updating off: entry applies at next epoch
// RL9 - alignment and steering continue whenever fix valid
// RL10 - auto mode computes last Sundays March, October
// RL11 - shift switches at 01:00:00 UTC, fixed
// RL12 - shift is set hours, default one
// RL13 - manual mode uses entered dates and shift
// RL14 - off mode never applies the shift
// RL15 - saving settings kept nonvolatile, restored after loss
// RL16 - compensation limited to 3000 ns, sign advances
// RL17 - zero compensation aligns for standard antenna path
// RL18 - each pulse output gated or free running
// RL19 - each pulse long 500 ms or short 10 us
// RL20 - pulse outputs default free running and long
// RL21 - events stamped in UTC or local time
// RL22 - event marker from pulse input or serial hash
// RL23 - up to eight stamps, numbered from one
// RL24 - shift added only between start and end
`ifndef TPC_PARAMS_SVH
`define TPC_PARAMS_SVH

// ------------------------------------------------------------
// register word offsets
// ------------------------------------------------------------
`define TPC_REG_CTRL     4'h0
`define TPC_REG_ZONE     4'h1
`define TPC_REG_DST      4'h2
`define TPC_REG_COMP     4'h3
`define TPC_REG_PULSE    4'h4
`define TPC_REG_DATE     4'h5
`define TPC_REG_TIME     4'h6
`define TPC_REG_LOCAL    4'h7
`define TPC_REG_STATUS   4'h8
`define TPC_REG_EV_IDX   4'h9
`define TPC_REG_EV_DATA  4'hA

// ------------------------------------------------------------
// field positions, reset values and limits
// ------------------------------------------------------------
`define TPC_STAT_REFUSED 2
`define TPC_DST_SHIFT_RST 2'h1
`define TPC_COMP_MAX     13'sh0BB8
`define TPC_EV_DEPTH     4'h8

// ------------------------------------------------------------
// calendar constants
// ------------------------------------------------------------
`define TPC_DAY_SEC      17'h1_5180
`define TPC_HOUR_SEC     19'h0_0E10
`define TPC_MIN_SEC      19'h0_003C
`define TPC_DST_SWITCH   17'h0_0E10
`define TPC_MAR31_DAY    9'h059
`define TPC_OCT31_DAY    9'h12F
`define TPC_YEAR_LAST    9'h16C

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define TPC_CLK_NS       10
`define TPC_SEC_MS       1000
`define TPC_LONG_MS      500
`define TPC_SHORT_US     10
`define TPC_ALIGN_NS     200
`define TPC_SEC_CYC      ((`TPC_SEC_MS * 1000000) / `TPC_CLK_NS)
`define TPC_LONG_CYC     ((`TPC_LONG_MS * 1000000) / `TPC_CLK_NS)
`define TPC_SHORT_CYC    ((`TPC_SHORT_US * 1000) / `TPC_CLK_NS)
`define TPC_ALIGN_CYC    ((`TPC_ALIGN_NS + `TPC_CLK_NS - 1) / `TPC_CLK_NS)
`define TPC_CNT_W        27

`endif

// File: hw/tpc_pkg.sv
// types shared by the timescale and pulse control design
// assumes tpc_params.svh defines the counter width
`include "tpc_params.svh"

package tpc_pkg;

	// saving-time modes
	typedef enum logic [1:0] {
		TPC_DST_OFF    = 2'h0,
		TPC_DST_AUTO   = 2'h1,
		TPC_DST_MANUAL = 2'h2
	} tpc_dst_mode_e;

	// saving-time settings, the part that is kept nonvolatile
	typedef struct packed {
		tpc_dst_mode_e mode;
		logic [1:0]    shift;
		logic [8:0]    start_day;
		logic [8:0]    end_day;
	} tpc_dst_s;

	// panel control bits
	typedef struct packed {
		logic ac_mask;
		logic dc_mask;
		logic osc_hold;
		logic alarm_special;
		logic buzzer_mute;
		logic receiver_time_update_off;
		logic ev_serial;
		logic ev_local;
	} tpc_ctrl_s;

	// one pulse output setting
	typedef struct packed {
		logic gate;
		logic short_w;
	} tpc_pulse_cfg_s;

	// day of year and second of day
	typedef struct packed {
		logic [8:0]  day;
		logic [16:0] sec;
	} tpc_time_s;

	// pulse generator state
	typedef struct packed {
		logic        on;
		logic [25:0] left;
	} tpc_pulse_state_s;

	// whole state of the control block
	typedef struct packed {
		tpc_ctrl_s             ctrl;
		logic                  tz_neg;
		logic [4:0]            tz_hour;
		logic [5:0]            tz_min;
		tpc_dst_s              dst;
		logic signed [12:0]    comp;
		tpc_pulse_cfg_s        pulse_output_a_setting;
		tpc_pulse_cfg_s        pulse_output_b_setting;
		logic [2:0]            jan1_wd;
		logic                  leap;
		tpc_time_s             utc;
		tpc_time_s             pending;
		logic                  pend_v;
		logic [`TPC_CNT_W-1:0] sec_cnt;
		logic                  refused;
		logic [3:0]            ev_idx;
		logic [3:0]            ev_cnt;
		logic [7:0][25:0]      ev_log;
		logic                  ev_prev;
		logic                  bus_wait;
		logic [31:0]           rdata;
		logic                  ac_f;
		logic                  dc_f;
		logic                  steer;
		logic                  aux;
		logic                  buzz;
		logic                  epoch;
		logic                  start;
	} tpc_state_s;

endpackage

// File: hw/tpc_pulse_gen.sv
// one timing pulse output: long or short, gated or free running
// assumes start_i is a one-cycle pulse once per second
`timescale 1ns/1ps
`default_nettype none
`include "tpc_params.svh"

module tpc_pulse_gen #(
	parameter int unsigned LONG_CYC  = `TPC_LONG_CYC,
	parameter int unsigned SHORT_CYC = `TPC_SHORT_CYC
) (
	input  wire logic clk_i,
	input  wire logic sys_rst_i,
	input  wire logic start_i,
	input  wire logic enable_i,
	input  wire logic short_i,
	output var  logic pulse_o
);
	import tpc_pkg::*;

	tpc_pulse_state_s s_r;   // registered state
	tpc_pulse_state_s s_nxt; // next state

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		s_nxt = s_r;
		if (!enable_i) begin
			s_nxt = '0; // suppressed while gated off [RL18]
		end else if (start_i) begin
			s_nxt.on = 1'b1;
			// width from the chosen setting [RL19]
			s_nxt.left = short_i ? 26'(SHORT_CYC - 1) : 26'(LONG_CYC - 1);
		end else if (s_r.on) begin
			if (s_r.left == 26'h000_0000) begin
				s_nxt.on = 1'b0;
			end else begin
				s_nxt.left = s_r.left - 26'h000_0001;
			end
		end
	end

	// state register
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign pulse_o = s_r.on;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	gate_off_a: assert property (!enable_i |=> !pulse_o) // [RL18]
		else $error("pulse active while gated off");
	pulse_start_a: assert property (start_i && enable_i |=> pulse_o) // [RL19]
		else $error("pulse did not start");

endmodule // tpc_pulse_gen
`default_nettype wire

// File: hw/tpc_top.sv
// timescale management and timing pulse control with an Avalon-MM slave
// assumes all inputs synchronous to clk_i; receiver supplies fix and epoch
`timescale 1ns/1ps
`default_nettype none
`include "tpc_params.svh"

module tpc_top #(
	parameter int unsigned SEC_CYC  = `TPC_SEC_CYC,
	parameter int unsigned LONG_CYC = `TPC_LONG_CYC
) (
	input  wire logic           clk_i,
	input  wire logic           sys_rst_i,
	input  wire logic [3:0]     avs_address_i,
	input  wire logic           avs_read_i,
	input  wire logic           avs_write_i,
	input  wire logic [31:0]    avs_writedata_i,
	output var  logic [31:0]    avs_readdata_o,
	output var  logic           avs_waitrequest_o,
	input  wire logic           rx_fix_i,
	input  wire logic           rx_pps_i,
	input  wire tpc_pkg::tpc_time_s rx_time_i,
	input  wire logic           ac_fault_i,
	input  wire logic           dc_fault_i,
	input  wire logic           aux_alarm_i,
	input  wire logic           ev_pulse_i,
	input  wire logic           ev_hash_i,
	input  wire logic           nv_restore_i,
	input  wire tpc_pkg::tpc_dst_s nv_dst_i,
	output var  tpc_pkg::tpc_dst_s nv_dst_o,
	output var  logic           ac_fault_o,
	output var  logic           dc_fault_o,
	output var  logic           osc_steer_en_o,
	output var  logic           aux_alarm_o,
	output var  logic           buzzer_o,
	output var  logic           epoch_o,
	output var  logic           pps_a_o,
	output var  logic           pps_b_o
);
	import tpc_pkg::*;

	tpc_state_s         s_r;     // registered state
	tpc_state_s         s_nxt;   // next state
	logic               req;     // bus request present
	logic               acc;     // request completes this edge
	logic               set_wr;  // time entry accepted this edge
	logic [8:0]         mar_end; // last day of march
	logic [8:0]         oct_end; // last day of october
	logic [2:0]         wd_m;    // weekday of mar_end
	logic [2:0]         wd_o;    // weekday of oct_end
	logic               dst_on;  // shift currently applied
	logic signed [18:0] zone;    // offset in seconds
	logic signed [18:0] loc_raw; // utc second plus offset
	tpc_time_s          loc;     // local time
	logic [1:0]         loc_dd;  // local day change
	logic signed [31:0] ph_raw;  // pulse phase before wrap
	logic [`TPC_CNT_W-1:0] phase; // cycle where pulses start
	logic               wrap;    // free-running second end
	logic               rx_al;   // receiver epoch accepted
	logic               ev_hit;  // event marker seen
	logic signed [12:0] cv;      // written compensation

	// ------------------------------------------------------------
	// calendar and local time
	// ------------------------------------------------------------
	always_comb begin
		// last sundays from the weekday of the first of january [RL10]
		mar_end = `TPC_MAR31_DAY + {8'h00, s_r.leap};
		oct_end = `TPC_OCT31_DAY + {8'h00, s_r.leap};
		wd_m = 3'((10'(s_r.jan1_wd) + 10'(mar_end)) % 10'h007);
		wd_o = 3'((10'(s_r.jan1_wd) + 10'(oct_end)) % 10'h007);
		// shift between the switching instants at 01:00:00 UTC [RL11] [RL24]
		dst_on = (s_r.dst.mode != TPC_DST_OFF) // [RL14]
			&& ((s_r.utc.day > s_r.dst.start_day)
			|| (s_r.utc.day == s_r.dst.start_day && s_r.utc.sec >= `TPC_DST_SWITCH))
			&& !((s_r.utc.day > s_r.dst.end_day)
			|| (s_r.utc.day == s_r.dst.end_day && s_r.utc.sec >= `TPC_DST_SWITCH));
		// zone offset independent of the shift [RL4]
		zone = 19'(s_r.tz_hour) * `TPC_HOUR_SEC + 19'(s_r.tz_min) * `TPC_MIN_SEC;
		if (s_r.tz_neg) begin
			zone = -zone;
		end
		if (dst_on) begin
			zone = zone + 19'(s_r.dst.shift) * `TPC_HOUR_SEC; // [RL12] [RL13]
		end
		loc_raw = 19'(s_r.utc.sec) + zone;
		loc.day = s_r.utc.day;
		loc_dd = 2'h0;
		if (loc_raw < 19'sh0_0000) begin
			loc.sec = 17'(loc_raw + 19'(`TPC_DAY_SEC));
			loc.day = s_r.utc.day - 9'h001;
			loc_dd = 2'h3;
		end else if (loc_raw >= 19'(`TPC_DAY_SEC)) begin
			loc.sec = 17'(loc_raw - 19'(`TPC_DAY_SEC));
			loc.day = s_r.utc.day + 9'h001;
			loc_dd = 2'h1;
		end else begin
			loc.sec = 17'(loc_raw);
		end
	end

	// ------------------------------------------------------------
	// second counter phase and events
	// ------------------------------------------------------------
	always_comb begin
		// fixed path delay, then signed offset: positive fires earlier [RL16] [RL17]
		ph_raw = 32'(SEC_CYC) - 32'(`TPC_ALIGN_CYC) - 32'(s_r.comp / 13'sh000A);
		if (ph_raw >= 32'(SEC_CYC)) begin
			ph_raw = ph_raw - 32'(SEC_CYC);
		end
		phase = `TPC_CNT_W'(ph_raw);
		wrap = s_r.sec_cnt == `TPC_CNT_W'(SEC_CYC - 1);
		// alignment follows the receiver whenever it has a fix [RL9]
		rx_al = rx_fix_i && rx_pps_i;
		// marker source selection [RL22]
		ev_hit = s_r.ctrl.ev_serial ? ev_hash_i : (ev_pulse_i && !s_r.ev_prev);
		req = avs_read_i || avs_write_i;
		acc = req && !s_r.bus_wait;
		set_wr = acc && avs_write_i && avs_address_i == `TPC_REG_TIME;
		// clamp the whole signed word before narrowing, so large values saturate [RL16]
		cv = avs_writedata_i[12:0];
		if ($signed(avs_writedata_i) > 32'(`TPC_COMP_MAX)) begin
			cv = `TPC_COMP_MAX;
		end else if ($signed(avs_writedata_i) < -32'(`TPC_COMP_MAX)) begin
			cv = -`TPC_COMP_MAX;
		end
	end

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		s_nxt = s_r;
		s_nxt.buzz = 1'b0;
		s_nxt.epoch = 1'b0;
		s_nxt.ev_prev = ev_pulse_i;
		s_nxt.start = s_r.sec_cnt == phase;

		// one wait cycle, then the request completes
		s_nxt.bus_wait = !(req && s_r.bus_wait);
		if (req && s_r.bus_wait && avs_read_i) begin
			s_nxt.rdata = 32'h0000_0000;
			case (avs_address_i)
				`TPC_REG_CTRL: s_nxt.rdata = {24'h00_0000, s_r.ctrl};
				`TPC_REG_ZONE: s_nxt.rdata = {16'h0000, s_r.tz_neg, 1'b0,
					s_r.tz_min, 3'h0, s_r.tz_hour};
				`TPC_REG_DST: s_nxt.rdata = {10'h000, s_r.dst};
				`TPC_REG_COMP: s_nxt.rdata = 32'(s_r.comp);
				`TPC_REG_PULSE: s_nxt.rdata = {28'h000_0000,
					s_r.pulse_output_b_setting, s_r.pulse_output_a_setting};
				`TPC_REG_DATE: s_nxt.rdata = {28'h000_0000, s_r.leap, s_r.jan1_wd};
				`TPC_REG_TIME: s_nxt.rdata = {6'h00, s_r.utc};
				`TPC_REG_LOCAL: s_nxt.rdata = {4'h0, loc_dd, loc};
				`TPC_REG_STATUS: s_nxt.rdata = {22'h00_0000, s_r.dc_f, s_r.ac_f,
					s_r.ev_cnt, s_r.pend_v, s_r.refused, dst_on, rx_fix_i};
				`TPC_REG_EV_IDX: s_nxt.rdata = {28'h000_0000, s_r.ev_idx};
				`TPC_REG_EV_DATA: begin
					// entries numbered one to eight [RL23]
					if (s_r.ev_idx != 4'h0 && s_r.ev_idx <= s_r.ev_cnt) begin
						s_nxt.rdata = {6'h00, s_r.ev_log[3'(s_r.ev_idx - 4'h1)]};
					end
				end
				default: s_nxt.rdata = 32'h0000_0000;
			endcase
		end

		// register writes
		if (acc && avs_write_i) begin
			case (avs_address_i)
				`TPC_REG_CTRL: s_nxt.ctrl = avs_writedata_i[7:0];
				`TPC_REG_ZONE: begin
					s_nxt.tz_hour = avs_writedata_i[4:0];
					s_nxt.tz_min = avs_writedata_i[13:8];
					s_nxt.tz_neg = avs_writedata_i[15];
				end
				`TPC_REG_DST: s_nxt.dst = avs_writedata_i[21:0];
				`TPC_REG_COMP: s_nxt.comp = cv;
				`TPC_REG_PULSE: begin
					s_nxt.pulse_output_a_setting = avs_writedata_i[1:0];
					s_nxt.pulse_output_b_setting = avs_writedata_i[3:2];
				end
				`TPC_REG_DATE: begin
					s_nxt.jan1_wd = avs_writedata_i[2:0];
					s_nxt.leap = avs_writedata_i[3];
				end
				`TPC_REG_STATUS: begin
					if (avs_writedata_i[`TPC_STAT_REFUSED]) begin
						s_nxt.refused = 1'b0;
					end
				end
				`TPC_REG_EV_IDX: s_nxt.ev_idx = avs_writedata_i[3:0];
				`TPC_REG_EV_DATA: s_nxt.ev_cnt = 4'h0;
				default: s_nxt.ev_idx = s_r.ev_idx;
			endcase
		end

		// saving settings restored from nonvolatile store [RL15]
		if (nv_restore_i) begin
			s_nxt.dst = nv_dst_i;
		end
		// automatic mode overwrites the dates [RL10]
		if (s_nxt.dst.mode == TPC_DST_AUTO) begin
			s_nxt.dst.start_day = mar_end - 9'(wd_m);
			s_nxt.dst.end_day = oct_end - 9'(wd_o);
		end

		// second counting and epochs
		if (wrap || rx_al) begin
			s_nxt.sec_cnt = '0;
			s_nxt.epoch = 1'b1;
			if (rx_al && !s_r.ctrl.receiver_time_update_off) begin
				s_nxt.utc = rx_time_i; // receiver overwrites entry [RL7]
				s_nxt.pend_v = 1'b0;
			end else if (s_r.pend_v) begin
				s_nxt.utc = s_r.pending; // entry takes effect at epoch [RL8]
				s_nxt.pend_v = 1'b0;
			end else if (s_r.utc.sec == `TPC_DAY_SEC - 17'h0_0001) begin
				s_nxt.utc.sec = 17'h0_0000;
				if (s_r.utc.day == `TPC_YEAR_LAST + {8'h00, s_r.leap}) begin
					s_nxt.utc.day = 9'h000;
					s_nxt.jan1_wd = 3'((4'(s_r.jan1_wd) + 4'h1 + 4'(s_r.leap)) % 4'h7);
				end else begin
					s_nxt.utc.day = s_r.utc.day + 9'h001;
				end
			end else begin
				s_nxt.utc.sec = s_r.utc.sec + 17'h0_0001;
			end
		end else begin
			s_nxt.sec_cnt = s_r.sec_cnt + `TPC_CNT_W'(1);
		end

		// manual time entry
		if (set_wr) begin
			if (s_r.ctrl.receiver_time_update_off) begin
				s_nxt.pending = avs_writedata_i[25:0]; // [RL8]
				s_nxt.pend_v = 1'b1;
			end else if (rx_fix_i) begin
				s_nxt.refused = 1'b1; // entry refused, beep [RL5]
				s_nxt.buzz = !s_r.ctrl.buzzer_mute;
			end else begin
				s_nxt.utc = avs_writedata_i[25:0]; // realign now [RL6]
				s_nxt.sec_cnt = '0;
				s_nxt.epoch = 1'b1;
				s_nxt.pend_v = 1'b0;
			end
		end

		// event stamps in the chosen timescale, at most eight [RL21] [RL23]
		if (ev_hit && s_r.ev_cnt < `TPC_EV_DEPTH) begin
			s_nxt.ev_log[3'(s_r.ev_cnt)] = s_r.ctrl.ev_local ? loc : s_r.utc;
			s_nxt.ev_cnt = s_r.ev_cnt + 4'h1;
		end

		// masked faults never raise an indication [RL1]
		s_nxt.ac_f = ac_fault_i && !s_r.ctrl.ac_mask;
		s_nxt.dc_f = dc_fault_i && !s_r.ctrl.dc_mask;
		// steering only with a fix and the loop running [RL2] [RL9]
		s_nxt.steer = rx_fix_i && !s_r.ctrl.osc_hold;
		// special mode has no second role, so the alarm passes as normal [RL3]
		s_nxt.aux = aux_alarm_i;
	end

	// state register; pulse settings reset to free running long [RL20]
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			s_r <= '0;
			s_r.bus_wait <= 1'b1;
			s_r.dst.shift <= `TPC_DST_SHIFT_RST; // [RL12]
		end else begin
			s_r <= s_nxt;
		end
	end

	// ------------------------------------------------------------
	// pulse outputs
	// ------------------------------------------------------------
	tpc_pulse_gen #(
		.LONG_CYC  (LONG_CYC),
		.SHORT_CYC (`TPC_SHORT_CYC)
	) u_pulse_a (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.start_i   (s_r.start),
		.enable_i  (!s_r.pulse_output_a_setting.gate || rx_fix_i),
		.short_i   (s_r.pulse_output_a_setting.short_w),
		.pulse_o   (pps_a_o)
	);

	tpc_pulse_gen #(
		.LONG_CYC  (LONG_CYC),
		.SHORT_CYC (`TPC_SHORT_CYC)
	) u_pulse_b (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.start_i   (s_r.start),
		.enable_i  (!s_r.pulse_output_b_setting.gate || rx_fix_i),
		.short_i   (s_r.pulse_output_b_setting.short_w),
		.pulse_o   (pps_b_o)
	);

	// outputs straight from the state register
	assign avs_readdata_o    = s_r.rdata;
	assign avs_waitrequest_o = s_r.bus_wait;
	assign nv_dst_o          = s_r.dst;
	assign ac_fault_o        = s_r.ac_f;
	assign dc_fault_o        = s_r.dc_f;
	assign osc_steer_en_o    = s_r.steer;
	assign aux_alarm_o       = s_r.aux;
	assign buzzer_o          = s_r.buzz;
	assign epoch_o           = s_r.epoch;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	ac_mask_a: assert property (s_r.ctrl.ac_mask |=> !ac_fault_o) // [RL1]
		else $error("masked mains fault shown");
	dc_mask_a: assert property (dc_fault_i && !s_r.ctrl.dc_mask |=> dc_fault_o) // [RL1]
		else $error("battery fault lost");
	loop_hold_a: assert property (s_r.ctrl.osc_hold |=> !osc_steer_en_o) // [RL2]
		else $error("steering while held");
	steer_fix_a: assert property (rx_fix_i && !s_r.ctrl.osc_hold |=> osc_steer_en_o) // [RL9]
		else $error("steering stopped with fix");
	entry_refuse_a: assert property (set_wr && !s_r.ctrl.receiver_time_update_off // [RL5]
		&& rx_fix_i |=> s_r.refused && $stable(s_r.utc.day))
		else $error("entry not refused");
	entry_realign_a: assert property (set_wr && !s_r.ctrl.receiver_time_update_off // [RL6]
		&& !rx_fix_i |=> s_r.sec_cnt == '0 && epoch_o && s_r.utc == $past(avs_writedata_i[25:0]))
		else $error("entry not realigned");
	pend_epoch_a: assert property (s_r.pend_v && wrap && !rx_al && !set_wr // [RL8]
		|=> s_r.utc == $past(s_r.pending) && !s_r.pend_v)
		else $error("pending entry not applied");
	rx_over_a: assert property (rx_al && !s_r.ctrl.receiver_time_update_off && !set_wr // [RL7]
		|=> s_r.utc == $past(rx_time_i))
		else $error("receiver time not loaded");
	comp_range_a: assert property (s_r.comp <= `TPC_COMP_MAX // [RL16]
		&& s_r.comp >= -`TPC_COMP_MAX)
		else $error("compensation out of range");
	dst_off_a: assert property (s_r.dst.mode == TPC_DST_OFF |-> !dst_on) // [RL14]
		else $error("shift applied while off");
	ev_depth_a: assert property (s_r.ev_cnt <= `TPC_EV_DEPTH) // [RL23]
		else $error("event count beyond eight");

	refuse_c: cover property (set_wr && rx_fix_i ##1 buzzer_o);
	realign_c: cover property (set_wr && !rx_fix_i ##1 epoch_o);
	dst_c: cover property (!dst_on ##1 dst_on);
	ev_full_c: cover property (s_r.ev_cnt == `TPC_EV_DEPTH);

endmodule // tpc_top
`default_nettype wire

// File: verification/tb_timescale_pulse_control.sv
// self-checking bench for the timescale and pulse control block
// assumes tpc_pkg compiled first; short second count for fast runs
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_total++; \
	$display("FAIL %0t got %h exp %h", $time, g, e); end end

module tb_timescale_pulse_control;
	import tpc_pkg::*;
	// ----------------------------------------
	// stimulus and observed signals
	// ----------------------------------------
	logic clk_i = 0, sys_rst_i = 1, avs_read_i = 0, avs_write_i = 0;
	logic [3:0]  avs_address_i = 0;
	logic [31:0] avs_writedata_i = 0, avs_readdata_o, q;
	logic avs_waitrequest_o, rx_fix_i = 0, rx_pps_i = 0, ac_fault_i = 0, dc_fault_i = 0;
	logic aux_alarm_i = 0, ev_pulse_i = 0, ev_hash_i = 0, nv_restore_i = 0;
	tpc_time_s rx_time_i = '0;
	tpc_dst_s  nv_dst_i = '0, nv_dst_o;
	logic ac_fault_o, dc_fault_o, osc_steer_en_o, aux_alarm_o, buzzer_o, epoch_o;
	logic pps_a_o, pps_b_o;
	int   err_total = 0, cmp_count = 0, buzz_n = 0, ep_n = 0, h, b0;

	tpc_top #(.SEC_CYC(2000), .LONG_CYC(500)) tpc_top_i (.clk_i(clk_i),
		.sys_rst_i(sys_rst_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
		.avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
		.avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
		.rx_fix_i(rx_fix_i), .rx_pps_i(rx_pps_i), .rx_time_i(rx_time_i),
		.ac_fault_i(ac_fault_i), .dc_fault_i(dc_fault_i), .aux_alarm_i(aux_alarm_i),
		.ev_pulse_i(ev_pulse_i), .ev_hash_i(ev_hash_i), .nv_restore_i(nv_restore_i),
		.nv_dst_i(nv_dst_i), .nv_dst_o(nv_dst_o), .ac_fault_o(ac_fault_o),
		.dc_fault_o(dc_fault_o), .osc_steer_en_o(osc_steer_en_o),
		.aux_alarm_o(aux_alarm_o), .buzzer_o(buzzer_o), .epoch_o(epoch_o),
		.pps_a_o(pps_a_o), .pps_b_o(pps_b_o));

	// 100 MHz clock
	initial begin
		forever #5 clk_i = ~clk_i;
	end

	// pulse counters for one-cycle outputs, sampled mid-cycle
	always @(negedge clk_i) begin
		if (buzzer_o === 1'b1) buzz_n++;
		if (epoch_o === 1'b1) ep_n++;
	end

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic close_out();
		$display("compares %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// one bus cycle, called just after a rising edge: request held until
	// waitrequest is sampled low at a rising edge, data taken and released there
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		avs_address_i <= a;
		avs_writedata_i <= d;
		avs_read_i <= !w;
		avs_write_i <= w;
		do begin
			@(posedge clk_i);
			n++;
		end while (avs_waitrequest_o !== 1'b0 && n < 50);
		q = avs_readdata_o;
		avs_read_i <= 1'b0;
		avs_write_i <= 1'b0;
		if (n >= 50) begin
			err_total++;
			close_out();
		end
		@(posedge clk_i);
	endtask

	// cycles of the next high phase of output a (b=0) or b (b=1), 0 when none
	task automatic pw(input logic b, output int hi);
		int n;
		n = 0;
		hi = 0;
		while ((b ? pps_b_o : pps_a_o) !== 1'b0 && n < 3000) begin @(posedge clk_i); n++; end
		while ((b ? pps_b_o : pps_a_o) !== 1'b1 && n < 6000) begin @(posedge clk_i); n++; end
		while ((b ? pps_b_o : pps_a_o) === 1'b1 && hi < 3000) begin @(posedge clk_i); hi++; end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset();
		bus(0, 4'h0, 0); `CHK(q, 32'h0000_0000)
		bus(0, 4'h2, 0); `CHK(q, 32'h0004_0000)
		bus(0, 4'h4, 0); `CHK(q, 32'h0000_0000)
		bus(0, 4'h7, 0); `CHK(q, 32'h0000_0000)
		`CHK(nv_dst_o, 22'h04_0000)
	endtask

	task automatic t_ctrl();
		ac_fault_i <= 1; dc_fault_i <= 1; rx_fix_i <= 1; aux_alarm_i <= 1;
		bus(1, 4'h0, 32'h0000_0080); cyc(2);
		`CHK({ac_fault_o, dc_fault_o}, 2'b01)
		bus(1, 4'h0, 32'h0000_0040); cyc(2);
		`CHK({ac_fault_o, dc_fault_o}, 2'b10)
		`CHK(osc_steer_en_o, 1'b1)
		bus(1, 4'h0, 32'h0000_0030); cyc(2);
		`CHK(osc_steer_en_o, 1'b0)
		`CHK(aux_alarm_o, 1'b1)
		bus(1, 4'h0, 32'h0000_0004); cyc(2);
		`CHK(osc_steer_en_o, 1'b1)
	endtask

	task automatic t_comp();
		bus(1, 4'h3, 32'h0000_1388); bus(0, 4'h3, 0); `CHK(q, 32'h0000_0BB8)
		bus(1, 4'h3, 32'hFFFF_EC78); bus(0, 4'h3, 0); `CHK(q, 32'hFFFF_F448)
		bus(1, 4'h3, 32'h0000_0000);
	endtask

	task automatic t_time();
		bus(1, 4'h0, 32'h0000_0000); b0 = buzz_n;
		bus(1, 4'h6, 32'h0014_0064); cyc(3);
		`CHK(buzz_n - b0, 1)
		bus(0, 4'h8, 0); `CHK(q[2], 1'b1)
		rx_fix_i <= 0; b0 = ep_n;
		bus(1, 4'h6, 32'h000A_0064); cyc(2); `CHK(ep_n - b0 >= 1, 1'b1)
		bus(0, 4'h6, 0); `CHK(q, 32'h000A_0064)
		rx_time_i <= '{day: 9'h009, sec: 17'h0_0007}; rx_fix_i <= 1; rx_pps_i <= 1;
		cyc(1); rx_pps_i <= 0; cyc(2);
		bus(0, 4'h6, 0); `CHK(q, 32'h0012_0007)
		bus(1, 4'h1, 32'h0000_1E02);
		bus(0, 4'h7, 0); `CHK(q, 32'h0012_232F)
		bus(1, 4'h0, 32'h0000_0004); bus(1, 4'h6, 32'h0006_0032);
		bus(0, 4'h8, 0); `CHK(q[3], 1'b1)
		bus(0, 4'h6, 0); `CHK(q, 32'h0012_0007)
		b0 = ep_n; h = 0;
		while (ep_n == b0 && h < 2100) begin cyc(1); h++; end
		bus(0, 4'h6, 0); `CHK(q, 32'h0006_0032)
	endtask

	task automatic t_nv();
		nv_dst_i <= '{mode: TPC_DST_MANUAL, shift: 2'h2, start_day: 9'h00A, end_day: 9'h014};
		nv_restore_i <= 1; cyc(1); nv_restore_i <= 0; cyc(2);
		bus(0, 4'h2, 0); `CHK(q, 32'h0028_1414)
		`CHK(nv_dst_o, 22'h28_1414)
		bus(1, 4'h5, 0); bus(1, 4'h2, 32'h0014_0000);
		bus(0, 4'h2, 0); `CHK(q, 32'h0014_A92D)
	endtask

	task automatic t_ev();
		ev_pulse_i <= 1; cyc(1); ev_pulse_i <= 0; ev_hash_i <= 1; cyc(1); ev_hash_i <= 0;
		bus(1, 4'h0, 32'h0000_0007); ev_hash_i <= 1; cyc(1); ev_hash_i <= 0;
		bus(0, 4'h8, 0); `CHK(q[7:4], 4'h2)
		bus(1, 4'h9, 32'h0000_0001); bus(0, 4'hA, 0); `CHK(q, 32'h0006_0032)
		bus(1, 4'h9, 32'h0000_0002); bus(0, 4'hA, 0); `CHK(q, 32'h0006_235A)
	endtask

	task automatic t_pulse();
		pw(0, h); `CHK(h, 500)
		bus(1, 4'h4, 32'h0000_0001); pw(0, h); `CHK(h, 1000)
		rx_fix_i <= 0; pw(0, h); `CHK(h, 1000)
		bus(1, 4'h4, 32'h0000_0002); pw(0, h); `CHK(h, 0)
		pw(1, h); `CHK(h, 500)
	endtask

	initial begin
		cyc(12);
		sys_rst_i <= 0;
		cyc(1);
		t_reset(); t_ctrl(); t_comp(); t_time(); t_nv(); t_ev(); t_pulse();
		close_out();
	end
endmodule // tb_timescale_pulse_control
`default_nettype wire
